// >>> hdl/ssf_pkg.sv
/*
  Constants for the serial status flag logic: register offsets, bit
  positions, reset values and transmit state encodings.
  Assumes a single 10 MHz system clock and a plain strobe register port.
*/
// Function
// - Software writes only 0, after reading 1
// - Status register loads 0x84 on reset/low-power
// - Transmit-end and rx multiproc bit read-only
// - Tx-empty sets on enable clear or transfer
// - Tx-empty clears by 0-write or buffer write
// - Error-free reception sets rx-full
// - Rx-full clears by 0-write or buffer read
// - Error or rx-enable clear keep buffer, flag
// - Overrun sets when rx-full still set
// - Overrun keeps old character, drops new
// - Error flags halt receive; sync halts transmit
// - Framing error from first stop bit only
// - Framing error loads buffer, rx-full stays clear
// - Parity error on parity mismatch
// - Parity error loads buffer, rx-full stays clear
// - Clearing rx-enable keeps error flags
// - Transmit-end sets on enable clear or done
// - Transmit-end clears with tx-empty
// - Capture received multiproc bit in MP format
// - Rx multiproc bit held when rx-enable clears
// - Append tx multiproc bit in MP format
// - Tx multiproc bit ignored outside async MP tx
// - Rx interrupts withdraw on flag or enable clear
package ssf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] SSF_ADDR_STATUS = 3'h0;
  localparam logic [2:0] SSF_ADDR_TXBUF  = 3'h1;
  localparam logic [2:0] SSF_ADDR_RXBUF  = 3'h2;
  localparam logic [2:0] SSF_ADDR_CTRL   = 3'h3;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int SSF_TX_BUFFER_EMPTY_BIT = 7;
  localparam int SSF_RX_BUFFER_FULL_BIT = 6;
  localparam int SSF_OVR_BIT  = 5;
  localparam int SSF_FRM_BIT  = 4;
  localparam int SSF_PAR_BIT  = 3;
  localparam int SSF_TX_END_FLAG_BIT = 2;
  localparam int SSF_MPR_BIT  = 1;
  localparam int SSF_MPT_BIT  = 0;

  // Control register bit positions
  localparam int SSF_CTL_TXEN = 0;
  localparam int SSF_CTL_RXEN = 1;
  localparam int SSF_CTL_RIE  = 2;
  localparam int SSF_CTL_SYNC = 3;
  localparam int SSF_CTL_MP   = 4;
  localparam int SSF_CTL_ODD  = 5;
  localparam int SSF_CTL_STP2 = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SSF_STATUS_RST = 8'h84;
  localparam logic [7:0] SSF_CTRL_RST   = 8'h00;
  localparam logic [7:0] SSF_BYTE_ZERO  = 8'h00;

  // Transmit sequencer states, Gray along idle-load-send
  typedef enum logic [1:0] {
    SSF_TX_IDLE = 2'b00,
    SSF_TX_LOAD = 2'b01,
    SSF_TX_SEND = 2'b11
  } ssf_tx_state_t;

endpackage : ssf_pkg

// >>> hdl/ssf_status.sv
/*
  Serial status flag logic: status register, transmit/receive buffers,
  multiprocessor bits and receive error interrupt requests.
  Assumes shift engines outside pulse tx_take/tx_last/rx_done on mclk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module ssf_status (
  input  wire logic        mclk_in,        // System clock, 10 MHz
  input  wire logic        rst_b_in,       // Sync reset, active low
  input  wire logic        lowpwr_in,      // Low-power mode entry pulse
  input  wire logic [2:0]  addr_in,        // Register address
  input  wire logic [7:0]  wdata_in,       // Write data
  input  wire logic        wr_in,          // Write strobe
  input  wire logic        rd_in,          // Read strobe
  output logic      [7:0]  rdata_out,      // Read data, next cycle
  input  wire logic        tx_take_in,     // Shifter takes tx buffer
  input  wire logic        tx_last_in,     // Last tx bit sent
  input  wire logic        rx_done_in,     // Character fully received
  input  wire logic [7:0]  rx_data_in,     // Received data bits
  input  wire logic        rx_par_in,      // Received parity bit
  input  wire logic        rx_par_on_in,   // Parity checked this frame
  input  wire logic        rx_stop_in,     // First stop bit sample
  input  wire logic        rx_mp_in,       // Received multiproc bit
  output logic      [7:0]  tx_data_out,    // Character to shifter
  output logic             tx_mp_out,      // Multiproc bit to append
  output logic             tx_ready_out,   // Tx buffer holds a character
  output logic             tx_halt_out,    // Transmit stalled by errors
  output logic             rx_halt_out,    // Receive stalled by errors
  output logic             tx_enable_out,  // Transmit enable
  output logic             rx_enable_out,  // Receive enable
  output logic             ctrl_sync_out,  // Synchronous mode
  output logic             ctrl_odd_out,   // Odd parity selected
  output logic             ctrl_stop2_out, // Two stop bits configured
  output logic             rx_full_irq_out,  // Receive full request
  output logic             rx_error_irq_out  // Receive error request
);
  import ssf_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]    ctrl_reg;
  logic          tx_buffer_empty_reg, rx_buffer_full_reg;
  logic          overrun_flag_reg, framing_flag_reg, parity_flag_reg;
  logic          tx_end_flag_reg, rx_multiproc_bit_reg, tx_multiproc_bit_reg;
  logic [4:0]    seen_one_reg;
  logic [7:0]    tx_buffer_reg, rx_buffer_reg;
  logic [7:0]    rdata_reg;
  ssf_tx_state_t tx_state_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       rst_all;
  logic       wr_status, wr_txbuf, wr_ctrl, rd_status, rd_rxbuf;
  logic       txen, rxen, sync_mode, mp_mode, err_any;
  logic       tx_disable, rx_end, fr_err, par_err;
  logic [4:0] clr_ok;
  logic [7:0] status_now;

  assign rst_all   = !rst_b_in || lowpwr_in;
  assign wr_status = wr_in && (addr_in == SSF_ADDR_STATUS);
  assign wr_txbuf  = wr_in && (addr_in == SSF_ADDR_TXBUF);
  assign wr_ctrl   = wr_in && (addr_in == SSF_ADDR_CTRL);
  assign rd_status = rd_in && (addr_in == SSF_ADDR_STATUS);
  assign rd_rxbuf  = rd_in && (addr_in == SSF_ADDR_RXBUF);
  assign txen      = ctrl_reg[SSF_CTL_TXEN];
  assign rxen      = ctrl_reg[SSF_CTL_RXEN];
  assign sync_mode = ctrl_reg[SSF_CTL_SYNC];
  assign mp_mode   = ctrl_reg[SSF_CTL_MP] && !sync_mode;
  assign err_any   = overrun_flag_reg || framing_flag_reg || parity_flag_reg;
  // Enable falling edge, seen as a write that drops the bit
  assign tx_disable = wr_ctrl && txen && !wdata_in[SSF_CTL_TXEN];
  // A finished character only counts while receive runs and no error blocks it
  assign rx_end    = rx_done_in && rxen && !err_any;
  assign fr_err    = !sync_mode && !rx_stop_in;
  assign par_err   = !sync_mode && rx_par_on_in &&
                     ((^rx_data_in ^ rx_par_in) != ctrl_reg[SSF_CTL_ODD]);

  // Clear by 0 only after a 1 was read: order TX_BUFFER_EMPTY,RX_BUFFER_FULL,OVR,FRM,PAR
  assign clr_ok[4] = wr_status && !wdata_in[SSF_TX_BUFFER_EMPTY_BIT] && seen_one_reg[4];
  assign clr_ok[3] = wr_status && !wdata_in[SSF_RX_BUFFER_FULL_BIT] && seen_one_reg[3];
  assign clr_ok[2] = wr_status && !wdata_in[SSF_OVR_BIT] && seen_one_reg[2];
  assign clr_ok[1] = wr_status && !wdata_in[SSF_FRM_BIT] && seen_one_reg[1];
  assign clr_ok[0] = wr_status && !wdata_in[SSF_PAR_BIT] && seen_one_reg[0];

  assign status_now = {tx_buffer_empty_reg, rx_buffer_full_reg, overrun_flag_reg,
                       framing_flag_reg, parity_flag_reg, tx_end_flag_reg,
                       rx_multiproc_bit_reg, tx_multiproc_bit_reg};

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      ctrl_reg <= SSF_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata_in;
    end
  end

  // Read-as-1 tracking; a new set re-arms nothing, any status write disarms all
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      seen_one_reg <= 5'h00;
    end else if (rd_status) begin
      seen_one_reg <= status_now[7:3];
    end else if (wr_status) begin
      seen_one_reg <= 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // Transmit side flags; set beats clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      tx_buffer_empty_reg <= SSF_STATUS_RST[SSF_TX_BUFFER_EMPTY_BIT];
    end else if (tx_disable || !txen || (tx_state_reg == SSF_TX_LOAD)) begin
      tx_buffer_empty_reg <= 1'b1;
    end else if (clr_ok[4] || wr_txbuf) begin
      tx_buffer_empty_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      tx_end_flag_reg <= SSF_STATUS_RST[SSF_TX_END_FLAG_BIT];
    end else if (tx_disable || (tx_last_in && tx_buffer_empty_reg)) begin
      tx_end_flag_reg <= 1'b1;
    end else if (clr_ok[4] || (wr_txbuf && txen)) begin
      tx_end_flag_reg <= 1'b0;
    end
  end

  // Software-owned transmit multiprocessor bit
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      tx_multiproc_bit_reg <= SSF_STATUS_RST[SSF_MPT_BIT];
    end else if (wr_status) begin
      tx_multiproc_bit_reg <= wdata_in[SSF_MPT_BIT];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      tx_buffer_reg <= SSF_BYTE_ZERO;
    end else if (wr_txbuf) begin
      tx_buffer_reg <= wdata_in;
    end
  end

  // Transfer sequencer: buffer to shifter handoff
  always_ff @(posedge mclk_in) begin
    if (rst_all || !txen) begin
      tx_state_reg <= SSF_TX_IDLE;
    end else begin
      case (tx_state_reg)
        SSF_TX_IDLE: begin
          if (tx_take_in && !tx_buffer_empty_reg && !tx_halt_out) begin
            tx_state_reg <= SSF_TX_LOAD;
          end
        end
        SSF_TX_LOAD: begin
          tx_state_reg <= SSF_TX_SEND;
        end
        default: begin
          if (tx_last_in) begin
            tx_state_reg <= SSF_TX_IDLE;
          end
        end
      endcase
    end
  end

  // Shifter-facing transmit outputs, registered
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      tx_data_out  <= SSF_BYTE_ZERO;
      tx_mp_out    <= 1'b0;
      tx_ready_out <= 1'b0;
      tx_halt_out  <= 1'b0;
    end else begin
      if (tx_state_reg == SSF_TX_LOAD) begin
        tx_data_out <= tx_buffer_reg;
        tx_mp_out   <= mp_mode && txen && tx_multiproc_bit_reg;
      end
      tx_ready_out <= txen && !tx_buffer_empty_reg;
      tx_halt_out  <= sync_mode && err_any;
    end
  end

  // ----------------------------------------------------------------
  // Receive side flags and buffer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      rx_buffer_reg <= SSF_BYTE_ZERO;
    end else if (rx_end && !rx_buffer_full_reg) begin
      rx_buffer_reg <= rx_data_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      rx_buffer_full_reg <= SSF_STATUS_RST[SSF_RX_BUFFER_FULL_BIT];
    end else if (rx_end && !rx_buffer_full_reg && !fr_err && !par_err) begin
      rx_buffer_full_reg <= 1'b1;
    end else if (clr_ok[3] || rd_rxbuf) begin
      rx_buffer_full_reg <= 1'b0;
    end
  end

  // Error flags are untouched by enable changes
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      overrun_flag_reg <= SSF_STATUS_RST[SSF_OVR_BIT];
    end else if (rx_end && rx_buffer_full_reg) begin
      overrun_flag_reg <= 1'b1;
    end else if (clr_ok[2]) begin
      overrun_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      framing_flag_reg <= SSF_STATUS_RST[SSF_FRM_BIT];
    end else if (rx_end && !rx_buffer_full_reg && fr_err) begin
      framing_flag_reg <= 1'b1;
    end else if (clr_ok[1]) begin
      framing_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      parity_flag_reg <= SSF_STATUS_RST[SSF_PAR_BIT];
    end else if (rx_end && !rx_buffer_full_reg && par_err) begin
      parity_flag_reg <= 1'b1;
    end else if (clr_ok[0]) begin
      parity_flag_reg <= 1'b0;
    end
  end

  // Hardware-only bit; software writes never reach it
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      rx_multiproc_bit_reg <= SSF_STATUS_RST[SSF_MPR_BIT];
    end else if (rx_end && mp_mode) begin
      rx_multiproc_bit_reg <= rx_mp_in;
    end
  end

  // ----------------------------------------------------------------
  // Read port and registered side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      rdata_reg <= SSF_BYTE_ZERO;
    end else if (rd_status) begin
      rdata_reg <= status_now;
    end else if (rd_in && (addr_in == SSF_ADDR_RXBUF)) begin
      rdata_reg <= rx_buffer_reg;
    end else if (rd_in && (addr_in == SSF_ADDR_TXBUF)) begin
      rdata_reg <= tx_buffer_reg;
    end else if (rd_in && (addr_in == SSF_ADDR_CTRL)) begin
      rdata_reg <= ctrl_reg;
    end else begin
      rdata_reg <= SSF_BYTE_ZERO;
    end
  end
  assign rdata_out = rdata_reg;

  // Requests follow flags one cycle late, so withdrawal lags by one too
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      rx_full_irq_out  <= 1'b0;
      rx_error_irq_out <= 1'b0;
      rx_halt_out      <= 1'b0;
      tx_enable_out    <= 1'b0;
      rx_enable_out    <= 1'b0;
      ctrl_sync_out    <= 1'b0;
      ctrl_odd_out     <= 1'b0;
      ctrl_stop2_out   <= 1'b0;
    end else begin
      rx_full_irq_out  <= rx_buffer_full_reg && ctrl_reg[SSF_CTL_RIE];
      rx_error_irq_out <= err_any && ctrl_reg[SSF_CTL_RIE];
      rx_halt_out      <= err_any;
      tx_enable_out    <= txen;
      rx_enable_out    <= rxen;
      ctrl_sync_out    <= sync_mode;
      ctrl_odd_out     <= ctrl_reg[SSF_CTL_ODD];
      ctrl_stop2_out   <= ctrl_reg[SSF_CTL_STP2];
    end
  end

endmodule // ssf_status
`default_nettype wire

// >>> tb/ssf_status_checker.sv
/*
  Checker for the serial status flag logic, bound to its top ports.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ssf_status_checker
  import ssf_pkg::*;
(
  input wire logic       mclk_in,          // System clock
  input wire logic       rst_b_in,         // Sync reset, active low
  input wire logic       lowpwr_in,        // Low-power entry
  input wire logic [2:0] addr_in,          // Register address
  input wire logic [7:0] wdata_in,         // Write data
  input wire logic       wr_in,            // Write strobe
  input wire logic       rd_in,            // Read strobe
  input wire logic [7:0] rdata_out,        // Read data
  input wire logic       tx_take_in,       // Shifter takes buffer
  input wire logic       tx_last_in,       // Last bit sent
  input wire logic       rx_done_in,       // Character complete
  input wire logic       rx_stop_in,       // First stop bit
  input wire logic [7:0] tx_data_out,      // Character to shifter
  input wire logic       tx_halt_out,      // Transmit stalled
  input wire logic       rx_halt_out,      // Receive stalled
  input wire logic       tx_enable_out,    // Transmit enable
  input wire logic       rx_enable_out,    // Receive enable
  input wire logic       ctrl_sync_out,    // Synchronous mode copy
  input wire logic       rx_full_irq_out,  // Receive full request
  input wire logic       rx_error_irq_out  // Receive error request
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  // Anything that may legally move a status bit between two reads
  logic ev;
  assign ev = tx_take_in | tx_last_in | rx_done_in | lowpwr_in;

  chk_lowpwr_read: assert property (lowpwr_in ##1 (rd_in && addr_in == SSF_ADDR_STATUS)
    |=> rdata_out == SSF_STATUS_RST) else $error("status not at initial value");
  chk_lowpwr_ctrl: assert property (lowpwr_in ##1 !wr_in
    |=> !tx_enable_out && !rx_enable_out && !rx_halt_out) else $error("low power kept state");
  chk_ones_ignored: assert property ((rd_in && addr_in == SSF_ADDR_STATUS && !ev)
    ##1 (wr_in && addr_in == SSF_ADDR_STATUS && wdata_in[7:1] == 7'h7F && !ev)
    ##1 (rd_in && addr_in == SSF_ADDR_STATUS && !ev)
    |=> rdata_out[7:1] == $past(rdata_out[7:1], 2)) else $error("write of ones moved a flag");
  chk_rxbuf_irq: assert property ((rd_in && addr_in == SSF_ADDR_RXBUF && !rx_done_in)
    ##1 !rx_done_in |=> !rx_full_irq_out) else $error("full request outlived buffer read");
  chk_error_irq: assert property (rx_error_irq_out |-> rx_halt_out)
    else $error("error request without error flag");
  chk_sync_halt: assert property (tx_halt_out |-> rx_halt_out)
    else $error("transmit halted without error flag");
  // Sync mode has no stop bit check, and a control write could raise the enable
  chk_frame_nofull: assert property (rx_done_in && !rx_stop_in && !rx_full_irq_out
    && !ctrl_sync_out && !$past(rx_done_in) && !$past(wr_in) && !wr_in
    ##1 !wr_in |=> !rx_full_irq_out)
    else $error("framing error raised full request");
  // A take moves the data two edges later: take, then the load state
  chk_tx_stable: assert property (!tx_take_in && !$past(tx_take_in)
    && !$past(tx_take_in, 2) && !$past(lowpwr_in)
    |-> $stable(tx_data_out)) else $error("tx data moved without a take");

  // Main scenarios reached
  cover property (rx_error_irq_out && rx_full_irq_out);
  cover property (tx_take_in && !tx_halt_out);
  cover property (tx_halt_out);
endmodule // ssf_status_checker

bind ssf_status ssf_status_checker ssf_status_checker_i (.mclk_in, .rst_b_in, .lowpwr_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .tx_take_in, .tx_last_in, .rx_done_in,
  .rx_stop_in, .tx_data_out, .tx_halt_out, .rx_halt_out, .tx_enable_out, .rx_enable_out,
  .ctrl_sync_out,
  .rx_full_irq_out, .rx_error_irq_out);
`default_nettype wire

// >>> tb/ssf_far_end.sv
/*
  Model of the shift engines and the line partner behind them.
  Assumes the bench calls send() just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ssf_far_end (
  input  wire logic       mclk_in,       // System clock
  input  wire logic       tx_ready_in,   // Buffer holds a character
  input  wire logic       tx_halt_in,    // Transmit stalled
  output logic            tx_take_out,   // Take the buffer
  output logic            tx_last_out,   // Last bit on the line
  output logic            rx_done_out,   // Character complete
  output logic      [7:0] rx_data_out,   // Received bits
  output logic            rx_par_out,    // Parity bit
  output logic            rx_par_on_out, // Parity present
  output logic            rx_stop_out,   // First stop bit
  output logic            rx_mp_out      // Multiproc bit
);
  int gap = 3;  // Bit times of one character, raised for a slow line

  // Quiet lines at start
  initial begin
    {tx_take_out, tx_last_out, rx_done_out, rx_par_out} = 4'h0;
    {rx_par_on_out, rx_stop_out, rx_mp_out, rx_data_out} = 11'h000;
  end

  // ----------------------------------------------------------------
  // Transmit side: take, shift for gap cycles, last bit
  // ----------------------------------------------------------------
  always begin
    @(posedge mclk_in);
    if (tx_ready_in && !tx_halt_in) begin
      tx_take_out <= 1'b1;
      @(posedge mclk_in);
      tx_take_out <= 1'b0;
      repeat (gap) @(posedge mclk_in);
      tx_last_out <= 1'b1;
      @(posedge mclk_in);
      tx_last_out <= 1'b0;
    end
  end

  // One received frame; stale fields flip so nothing reads as valid
  task automatic send(input logic [7:0] d, input logic s, pn, p, m);
    @(posedge mclk_in);
    {rx_data_out, rx_stop_out, rx_par_on_out, rx_par_out, rx_mp_out} <= {d, s, pn, p, m};
    rx_done_out <= 1'b1;
    @(posedge mclk_in);
    {rx_data_out, rx_stop_out, rx_par_on_out, rx_par_out, rx_mp_out} <= ~{d, s, pn, p, m};
    rx_done_out <= 1'b0;
  endtask
endmodule // ssf_far_end
`default_nettype wire

// >>> tb/ssf_status_tb_top.sv
/*
  Self-checking bench for the serial status flag logic.
  Assumes the far-end model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module ssf_status_tb_top;
  import ssf_pkg::*;
  localparam logic [2:0] AS = SSF_ADDR_STATUS;
  localparam logic [2:0] AT = SSF_ADDR_TXBUF;
  localparam logic [2:0] AR = SSF_ADDR_RXBUF;
  localparam logic [2:0] AC = SSF_ADDR_CTRL;
  logic       mclk_in, rst_b_in, lowpwr_in, wr_in, rd_in, tx_take, tx_last, rx_done;
  logic       rx_par, rx_par_on, rx_stop, rx_mp, tx_mp_out, tx_ready_out, tx_halt_out;
  logic       rx_halt_out, tx_enable_out, rx_full_irq_out, rx_error_irq;
  logic       rx_enable_out, ctrl_sync_out, ctrl_odd_out, ctrl_stop2_out;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out, tx_data_out, rx_data;
  int         fail_count = 0;
  int         check_count = 0;

  ssf_status ssf_status_i (.mclk_in, .rst_b_in, .lowpwr_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .tx_take_in(tx_take), .tx_last_in(tx_last), .rx_done_in(rx_done),
    .rx_data_in(rx_data), .rx_par_in(rx_par), .rx_par_on_in(rx_par_on), .rx_stop_in(rx_stop),
    .rx_mp_in(rx_mp), .tx_data_out, .tx_mp_out, .tx_ready_out, .tx_halt_out, .rx_halt_out,
    .tx_enable_out, .rx_enable_out, .ctrl_sync_out, .ctrl_odd_out, .ctrl_stop2_out,
    .rx_full_irq_out, .rx_error_irq_out(rx_error_irq));
  ssf_far_end ssf_far_end_i (.mclk_in, .tx_ready_in(tx_ready_out), .tx_halt_in(tx_halt_out),
    .tx_take_out(tx_take), .tx_last_out(tx_last), .rx_done_out(rx_done),
    .rx_data_out(rx_data), .rx_par_out(rx_par), .rx_par_on_out(rx_par_on),
    .rx_stop_out(rx_stop), .rx_mp_out(rx_mp));

  // 10 MHz system clock
  always #50 mclk_in = ~mclk_in;

  // ----------------------------------------------------------------
  // Bus and check tasks; strobes stay up until the next call changes them
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    {addr_in, wdata_in, wr_in, rd_in} <= {a, d, 2'b10};
    @(posedge mclk_in);
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
    {addr_in, wr_in, rd_in} <= {a, 2'b01};
    @(posedge mclk_in);
    #1;
    chk(n, e, rdata_out);
  endtask
  task automatic cyc(input int n);
    {wr_in, rd_in} <= 2'b00;
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic rx(input logic [7:0] d, input logic s, pn, p, m);
    cyc(1);
    ssf_far_end_i.send(d, s, pn, p, m);
    cyc(2);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about 140 cycles
  initial begin
    repeat (3000) @(posedge mclk_in);
    fail_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {mclk_in, rst_b_in, lowpwr_in, wr_in, rd_in, addr_in, wdata_in} = 16'h0000;
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    cyc(1);
    rd(AS, 8'h84, "status");
    wr(AS, 8'hFF);
    rd(AS, 8'h85, "status");
    rd(3'h5, 8'h00, "unmapped");
    wr(AC, 8'h07);
    wr(AT, 8'h5A);
    rd(AS, 8'h01, "status");
    cyc(12);
    rd(AS, 8'h85, "status");
    chk("tx data", 8'h5A, tx_data_out);
    chk("tx mp", 8'h00, {7'h00, tx_mp_out});
    ssf_far_end_i.gap = 20;
    wr(AC, 8'h17);
    wr(AT, 8'hA5);
    cyc(40);
    rd(AS, 8'h85, "status");
    chk("tx mp", 8'h01, {7'h00, tx_mp_out});
    rx(8'h3C, 1, 1, 0, 1);
    rd(AS, 8'hC7, "status");
    chk("full irq", 8'h01, {7'h00, rx_full_irq_out});
    rd(AR, 8'h3C, "rx buffer");
    rd(AS, 8'h87, "status");
    rx(8'h11, 1, 0, 0, 0);
    wr(AS, 8'hBF);
    rd(AS, 8'hC5, "status");
    rx(8'h22, 1, 0, 0, 0);
    rd(AS, 8'hE5, "status");
    chk("err irq", 8'h01, {7'h00, rx_error_irq});
    rx(8'h77, 1, 0, 0, 0);
    chk("rx halt", 8'h01, {7'h00, rx_halt_out});
    wr(AC, 8'h1F);
    cyc(2);
    chk("tx halt", 8'h01, {7'h00, tx_halt_out});
    chk("sync", 8'h01, {7'h00, ctrl_sync_out});
    wr(AC, 8'h17);
    rd(AR, 8'h11, "rx buffer");
    rd(AS, 8'hA5, "status");
    wr(AS, 8'hDF);
    rd(AS, 8'h85, "status");
    chk("err irq", 8'h00, {7'h00, rx_error_irq});
    rx(8'h33, 0, 0, 0, 0);
    rd(AS, 8'h95, "status");
    rd(AR, 8'h33, "rx buffer");
    wr(AC, 8'h15);
    rd(AS, 8'h95, "status");
    wr(AS, 8'hEF);
    rd(AS, 8'h85, "status");
    wr(AC, 8'h77);
    rx(8'h01, 1, 1, 1, 0);
    rd(AS, 8'h8D, "status");
    chk("ctrl", 8'h03, {6'h00, ctrl_stop2_out, ctrl_odd_out});
    rd(AR, 8'h01, "rx buffer");
    wr(AS, 8'hF7);
    rx(8'h44, 1, 0, 0, 1);
    rd(AS, 8'hC7, "status");
    rd(AR, 8'h44, "rx buffer");
    wr(AT, 8'h66);
    wr(AC, 8'h14);
    rx(8'h55, 1, 0, 0, 0);
    rd(AS, 8'h87, "status");
    chk("rx enable", 8'h00, {7'h00, rx_enable_out});
    {wr_in, rd_in, lowpwr_in} <= 3'b001;
    @(posedge mclk_in);
    #1;
    lowpwr_in <= 1'b0;
    rd(AS, 8'h84, "status");
    cyc(2);
    chk("tx enable", 8'h00, {7'h00, tx_enable_out});
    end_of_test();
  end
endmodule // ssf_status_tb_top
`default_nettype wire
